/* verilog/pbrc_consts.vh */
`ifndef PBRC_CONSTS_VH
`define PBRC_CONSTS_VH
// Overview of operation
// - System reset sets the voltage-sense flip-flop so software can test it later.
// - Voltage-sense input stays readable in backup mode and after power-on reset.
// - Supply-monitor falling to low sets power-off flag and hold interrupt flag.
// - Oscillator stop with monitor low enters backup; monitor high leaves it.
// - Reset input low one machine cycle resets device; restart at address 0.
// - Each analog-shared input bit selects digital or analog via control word one.
// - Converter channel from control word one; conversion starts on counter control.
// - Analog-selected bits read as low on the digital port path.
// - Analog-shared inputs read low while in backup mode.
// - Open-drain outputs released high in backup mode and after power-on reset.
// - Each external interrupt input acts only with its own enable set.
// - Bidirectional pins have direction set bit by bit.
// - In backup, bidirectional pins have input disabled and driver off.
// - After power-on reset every shared and bidirectional port is an input.
// - In tone mode, port writes to the tone bit update the latch only, not the pin.
// - Port-two group reached only by port-two read and write, not bit operations.
// - Oscillator stop has effect only while the supply monitor reads zero.

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define PBRC_A_ANALOG  8'h00
`define PBRC_A_DIR1    8'h04
`define PBRC_A_DIR2    8'h08
`define PBRC_A_TONE    8'h0c
`define PBRC_A_IRQEN   8'h10
`define PBRC_A_OUT1    8'h14
`define PBRC_A_ODOUT   8'h18
`define PBRC_A_OUT2    8'h1c
`define PBRC_A_BSET    8'h20
`define PBRC_A_BCLR    8'h24
`define PBRC_A_IN1     8'h28
`define PBRC_A_IN2     8'h2c
`define PBRC_A_AIN     8'h30
`define PBRC_A_STATUS  8'h34
`define PBRC_A_CMD     8'h38

// ----------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------
`define PBRC_W_ANA     8
`define PBRC_W_P1      20
`define PBRC_W_P2      14
`define PBRC_W_OD      4
`define PBRC_W_IRQ     4
`define PBRC_TONE_BIT  8
`define PBRC_ST_SENSE  0
`define PBRC_ST_SPIN   1
`define PBRC_ST_POFF   2
`define PBRC_ST_HIRQ   3
`define PBRC_ST_BACKUP 4
`define PBRC_ST_HPIN   5
`define PBRC_CMD_OSTOP 0
`define PBRC_CMD_CONV  1
`define PBRC_CH_LSB    8
`define PBRC_CH_MSB    10

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PBRC_CLK_NS    8
`define PBRC_MC_NS     1330
`define PBRC_MC_CYC    ((`PBRC_MC_NS + `PBRC_CLK_NS - 1) / `PBRC_CLK_NS)
`define PBRC_RESTART   16'h0000
`endif

/* verilog/pbrc_sync.v */
// ----------------------------------------------------------------
// Three-stage input filter
// ----------------------------------------------------------------
// A bit only changes once stages two and three agree, so a single
// metastable sample never reaches the logic.
module pbrc_sync #(
   parameter W = 1
) (
   input  wire         ref_clk,
   input  wire         rstn,
   input  wire [W-1:0] d,
   input  wire [W-1:0] init,
   output reg  [W-1:0] q
);
   reg [W-1:0] s1;
   reg [W-1:0] s2;
   reg [W-1:0] s3;
   integer i;

   always @(posedge ref_clk) begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      if (!rstn) begin
         q <= init;
      end else begin
         for (i = 0; i < W; i = i + 1) begin
            if (s2[i] == s3[i]) begin
               q[i] <= s3[i];
            end
         end
      end
   end
endmodule // pbrc_sync

/* verilog/pbrc_top.v */
`include "pbrc_consts.vh"

module pbrc_top (
   input  wire        ref_clk,
   input  wire        rstn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output wire        pready,
   output reg  [31:0] prdata,
   output reg         pslverr,
   input  wire        sense_pin,
   input  wire        hold_pin,
   input  wire        reset_pin_n,
   input  wire [7:0]  analog_pin,
   input  wire [19:0] p1_in,
   output wire [19:0] p1_out,
   output wire [19:0] p1_oe,
   input  wire [13:0] p2_in,
   output wire [13:0] p2_out,
   output wire [13:0] p2_oe,
   output wire [3:0]  od_out,
   output wire [3:0]  od_oe,
   input  wire        tone_wave,
   output reg  [3:0]  ext_irq,
   output wire        hold_irq,
   output wire        backup_mode,
   output reg         sys_reset,
   output reg         cpu_restart,
   output wire [15:0] restart_addr,
   output reg         conv_start,
   output wire [2:0]  conv_channel
);
   // ----------------------------------------------------------------
   // Pin filtering
   // ----------------------------------------------------------------
   wire [7:0]  ana_s;
   wire [19:0] p1_s;
   wire [13:0] p2_s;
   wire        sense_s;
   wire        hold_s;
   wire        rpin_s;

   // Reset and monitor pins start at their inactive high level, so leaving
   // reset shows neither a supply loss nor a held reset pin.
   pbrc_sync #(.W(1)) u_sync_rpin (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .d       (reset_pin_n),
      .init    (1'b1),
      .q       (rpin_s)
   );

   pbrc_sync #(.W(1)) u_sync_hold (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .d       (hold_pin),
      .init    (1'b1),
      .q       (hold_s)
   );

   // The sense pin stays readable in every mode, unlike the ports.
   pbrc_sync #(.W(1)) u_sync_sense (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .d       (sense_pin),
      .init    (1'b1),
      .q       (sense_s)
   );

   // Port pins start low, which matches the zero that the edge detector
   // holds after reset, so no false interrupt edge follows it.
   pbrc_sync #(.W(8)) u_sync_ana (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .d       (analog_pin),
      .init    (8'h00),
      .q       (ana_s)
   );

   pbrc_sync #(.W(20)) u_sync_p1 (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .d       (p1_in),
      .init    (20'h00000),
      .q       (p1_s)
   );

   pbrc_sync #(.W(14)) u_sync_p2 (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .d       (p2_in),
      .init    (14'h0000),
      .q       (p2_s)
   );

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   reg  [10:0] ana_cfg;
   reg  [19:0] dir1;
   reg  [13:0] dir2;
   reg         tone_sel;
   reg  [3:0]  irq_en;
   reg  [19:0] lat1;
   reg  [3:0]  od_lat;
   reg  [13:0] lat2;
   reg         sense_ff;
   reg         poff_flag;
   reg         hirq_flag;
   reg         backup;
   reg         hold_d;
   reg  [19:0] p1_d;
   reg  [7:0]  rst_cnt;

   wire wr_en = psel & penable & pwrite;
   wire cfg_rst = !rstn | sys_reset;

   assign pready = 1'b1;

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   // Read data is sampled in the setup cycle, so it stands registered
   // for the whole access phase.
   wire [7:0]  ana_rd = ana_s & ~ana_cfg[7:0] & {8{~backup}};
   wire [19:0] p1_rd  = p1_s & {20{~backup}};
   wire [13:0] p2_rd  = p2_s & {14{~backup}};
   wire [5:0]  status = {hold_s, backup, hirq_flag, poff_flag, sense_s, sense_ff};
   reg  [31:0] next_rdata;
   reg         next_err;

   // An unmapped address answers with an error and reads as zero; a
   // write to it changes nothing.
   always @* begin
      next_rdata = 32'h0;
      next_err   = 1'b0;
      if (paddr == `PBRC_A_ANALOG) begin
         next_rdata[10:0] = ana_cfg;
      end else if (paddr == `PBRC_A_DIR1) begin
         next_rdata[19:0] = dir1;
      end else if (paddr == `PBRC_A_DIR2) begin
         next_rdata[13:0] = dir2;
      end else if (paddr == `PBRC_A_TONE) begin
         next_rdata[0] = tone_sel;
      end else if (paddr == `PBRC_A_IRQEN) begin
         next_rdata[3:0] = irq_en;
      end else if (paddr == `PBRC_A_OUT1) begin
         next_rdata[19:0] = lat1;
      end else if (paddr == `PBRC_A_ODOUT) begin
         next_rdata[3:0] = od_lat;
      end else if (paddr == `PBRC_A_OUT2) begin
         next_rdata[13:0] = lat2;
      end else if (paddr == `PBRC_A_BSET || paddr == `PBRC_A_BCLR) begin
         next_rdata = 32'h0;
      end else if (paddr == `PBRC_A_IN1) begin
         next_rdata[19:0] = p1_rd;
      end else if (paddr == `PBRC_A_IN2) begin
         next_rdata[13:0] = p2_rd;
      end else if (paddr == `PBRC_A_AIN) begin
         next_rdata[7:0] = ana_rd;
      end else if (paddr == `PBRC_A_STATUS) begin
         next_rdata[5:0] = status;
      end else if (paddr == `PBRC_A_CMD) begin
         next_rdata = 32'h0;
      end else begin
         next_err = 1'b1;
      end
   end

   always @(posedge ref_clk) begin
      if (!rstn) begin
         prdata  <= 32'h0;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         prdata  <= pwrite ? 32'h0 : next_rdata;
         pslverr <= next_err;
      end
   end

   // ----------------------------------------------------------------
   // Port configuration and latches
   // ----------------------------------------------------------------
   // Any reset returns every port to input, analog pins to digital and
   // the open-drain latch to released.
   always @(posedge ref_clk) begin
      if (cfg_rst) begin
         ana_cfg  <= 11'h0;
         dir1     <= 20'h0;
         dir2     <= 14'h0;
         tone_sel <= 1'b0;
         irq_en   <= 4'h0;
         lat1     <= 20'h0;
         od_lat   <= 4'hf;
         lat2     <= 14'h0;
      end else if (wr_en && !pslverr) begin
         if (paddr == `PBRC_A_ANALOG) begin
            ana_cfg <= pwdata[10:0];
         end else if (paddr == `PBRC_A_DIR1) begin
            dir1 <= pwdata[19:0];
         end else if (paddr == `PBRC_A_DIR2) begin
            dir2 <= pwdata[13:0];
         end else if (paddr == `PBRC_A_TONE) begin
            tone_sel <= pwdata[0];
         end else if (paddr == `PBRC_A_IRQEN) begin
            irq_en <= pwdata[3:0];
         end else if (paddr == `PBRC_A_OUT1) begin
            lat1 <= pwdata[19:0];
         end else if (paddr == `PBRC_A_ODOUT) begin
            od_lat <= pwdata[3:0];
         end else if (paddr == `PBRC_A_OUT2) begin
            lat2 <= pwdata[13:0];
         end else if (paddr == `PBRC_A_BSET) begin
            lat1 <= lat1 | pwdata[19:0];
         end else if (paddr == `PBRC_A_BCLR) begin
            lat1 <= lat1 & ~pwdata[19:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Pin drive
   // ----------------------------------------------------------------
   // The tone pin drives whenever tone output is on outside backup; the latch keeps the
   // written value, so turning tone off restores it on the pin.
   wire [19:0] tone_mask = 20'h1 << `PBRC_TONE_BIT;
   assign p1_out = tone_sel ? ((lat1 & ~tone_mask) | ({20{tone_wave}} & tone_mask))
                            : lat1;
   assign p1_oe  = (dir1 | (tone_sel ? tone_mask : 20'h0)) & {20{~backup}};
   assign p2_out = lat2;
   assign p2_oe  = dir2 & {14{~backup}};
   assign od_out = 4'h0;
   assign od_oe  = ~od_lat & {4{~backup}};

   // ----------------------------------------------------------------
   // Converter control
   // ----------------------------------------------------------------
   // Only the channel select and the start pulse leave this block; the
   // conversion itself runs in the converter.
   assign conv_channel = ana_cfg[`PBRC_CH_MSB:`PBRC_CH_LSB];

   always @(posedge ref_clk) begin
      if (cfg_rst) begin
         conv_start <= 1'b0;
      end else begin
         conv_start <= wr_en && paddr == `PBRC_A_CMD && pwdata[`PBRC_CMD_CONV];
      end
   end

   // ----------------------------------------------------------------
   // External interrupts
   // ----------------------------------------------------------------
   // Only rising edges on pins that are inputs count; an output pin
   // toggling under software must not raise its own request.
   // A pin pulse shorter than the filter's agreement window is missed.
   always @(posedge ref_clk) begin
      if (!rstn) begin
         p1_d    <= 20'h0;
         ext_irq <= 4'h0;
      end else begin
         p1_d    <= p1_s;
         ext_irq <= irq_en & ~dir1[3:0] & p1_s[3:0] & ~p1_d[3:0] & {4{~backup}};
      end
   end

   // ----------------------------------------------------------------
   // Supply monitor and backup mode
   // ----------------------------------------------------------------
   wire st_wr = wr_en && paddr == `PBRC_A_STATUS;
   wire poff_evt = hold_d & ~hold_s;
   wire ostop = wr_en && paddr == `PBRC_A_CMD && pwdata[`PBRC_CMD_OSTOP];

   assign hold_irq    = hirq_flag;
   assign backup_mode = backup;

   always @(posedge ref_clk) begin
      if (!rstn) begin
         hold_d    <= 1'b1;
         poff_flag <= 1'b0;
         hirq_flag <= 1'b0;
      end else begin
         hold_d <= hold_s;
         // A new detection in the clearing cycle keeps the flag set.
         poff_flag <= poff_evt | (poff_flag & ~(st_wr & pwdata[`PBRC_ST_POFF]));
         hirq_flag <= poff_evt | (hirq_flag & ~(st_wr & pwdata[`PBRC_ST_HIRQ]));
      end
   end

   // Backup is left as soon as the monitor reads high again, even in the
   // cycle of a stop command, so a late stop never strands the device.
   always @(posedge ref_clk) begin
      if (!rstn) begin
         backup <= 1'b0;
      end else if (hold_s) begin
         backup <= 1'b0;
      end else if (ostop) begin
         backup <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Reset pin and voltage-sense flip-flop
   // ----------------------------------------------------------------
   // The sense flip-flop falls when the sense pin drops, which marks a
   // supply loss; only a reset sets it again.
   always @(posedge ref_clk) begin
      if (!rstn) begin
         rst_cnt     <= 8'h0;
         sys_reset   <= 1'b0;
         cpu_restart <= 1'b0;
      end else begin
         cpu_restart <= sys_reset & rpin_s;
         if (rpin_s) begin
            rst_cnt   <= 8'h0;
            sys_reset <= 1'b0;
         end else if (rst_cnt == `PBRC_MC_CYC - 1) begin
            sys_reset <= 1'b1;
         end else begin
            rst_cnt <= rst_cnt + 8'h1;
         end
      end
   end

   // Set by every reset, so software that finds it cleared knows that the
   // supply dropped at some time since that reset, in backup or not.
   always @(posedge ref_clk) begin
      if (!rstn) begin
         sense_ff <= 1'b1;
      end else if (sys_reset) begin
         sense_ff <= 1'b1;
      end else if (!sense_s) begin
         sense_ff <= 1'b0;
      end
   end

   assign restart_addr = `PBRC_RESTART;
endmodule // pbrc_top

/* verif/pbrc_chk.sv */
module pbrc_chk (
   input wire        ref_clk,
   input wire        rstn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [7:0]  paddr,
   input wire [31:0] pwdata,
   input wire        hold_pin,
   input wire        reset_pin_n,
   input wire [19:0] p1_oe,
   input wire [13:0] p2_oe,
   input wire [3:0]  od_oe,
   input wire        hold_irq,
   input wire        backup_mode,
   input wire        sys_reset,
   input wire        cpu_restart,
   input wire [15:0] restart_addr,
   input wire        conv_start
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // Pin and mode checks
   // ------------------------------------------------------------
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   wire acc     = psel && penable && pwrite;
   wire stop_wr = acc && paddr == 8'h38 && pwdata[0];
   wire conv_wr = acc && paddr == 8'h38 && pwdata[1];
   wire hclr_wr = acc && paddr == 8'h34 && pwdata[3];
   sequence s_stop; stop_wr; endsequence
   sequence s_conv; conv_wr; endsequence
   property p_bk_iso; backup_mode |-> p1_oe == 20'h0 && p2_oe == 14'h0; endproperty
   a_bk_iso: assert property (p_bk_iso) else $error("port driven in backup");
   property p_bk_od; backup_mode |-> od_oe == 4'h0; endproperty
   a_bk_od: assert property (p_bk_od) else $error("open drain on in backup");
   property p_por; $rose(rstn) |-> p1_oe == 20'h0 && p2_oe == 14'h0 && od_oe == 4'h0; endproperty
   a_por: assert property (p_por) else $error("pin enabled after reset");
   property p_enter; $rose(backup_mode) |-> $past(stop_wr); endproperty
   a_enter: assert property (p_enter) else $error("backup without stop");
   property p_nostop; hold_pin[*6] ##1 s_stop |=> !backup_mode; endproperty
   a_nostop: assert property (p_nostop) else $error("stop with monitor high");
   property p_leave; hold_pin[*7] |=> !backup_mode; endproperty
   a_leave: assert property (p_leave) else $error("backup kept");
   property p_conv; s_conv |-> ##[1:2] conv_start; endproperty
   a_conv: assert property (p_conv) else $error("conversion not started");
   property p_conv_only; conv_start |-> $past(conv_wr) || $past(conv_wr, 2); endproperty
   a_conv_only: assert property (p_conv_only) else $error("stray conversion");
   property p_hirq; hold_irq && !hclr_wr |=> hold_irq; endproperty
   a_hirq: assert property (p_hirq) else $error("hold flag lost");
   property p_restart; cpu_restart |-> $fell(sys_reset) && restart_addr == 16'h0; endproperty
   a_restart: assert property (p_restart) else $error("bad restart");
   property p_sys; $rose(sys_reset) |-> !$past(reset_pin_n, 4); endproperty
   a_sys: assert property (p_sys) else $error("reset without pin");
endmodule // pbrc_chk

bind pbrc_top pbrc_chk u_chk (.ref_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
   .hold_pin, .reset_pin_n, .p1_oe, .p2_oe, .od_oe, .hold_irq, .backup_mode, .sys_reset,
   .cpu_restart, .restart_addr, .conv_start);

/* verif/pbrc_board.sv */
module pbrc_board #(
   parameter int PWR_CYC = 300
) (
   input  wire        ref_clk,
   input  wire        rst_req,
   input  wire [19:0] p1_drv,
   input  wire [19:0] p1_out,
   input  wire [19:0] p1_oe,
   input  wire [13:0] p2_drv,
   input  wire [13:0] p2_out,
   input  wire [13:0] p2_oe,
   output wire [19:0] p1_in,
   output wire [13:0] p2_in,
   output wire        reset_pin_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // Board side
   // ------------------------------------------------------------
   int cnt = 0;
   always @(posedge ref_clk) if (cnt < PWR_CYC) cnt <= cnt + 1;
   // The power-up hold is scaled down to keep the run short.
   assign reset_pin_n = cnt >= PWR_CYC && !rst_req;
   assign p1_in = (p1_oe & p1_out) | (~p1_oe & p1_drv);
   assign p2_in = (p2_oe & p2_out) | (~p2_oe & p2_drv);
endmodule // pbrc_board

/* verif/tb_top.sv */
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk, rstn, psel, penable, pwrite, sense_pin, hold_pin, rst_req, rerr;
   logic [7:0]  paddr, analog_pin;
   logic [31:0] pwdata, rdat;
   logic [19:0] p1_drv;
   logic [13:0] p2_drv;
   logic [2:0]  tdiv;
   int          n_fail, check_count;
   wire         pready, pslverr, reset_pin_n, hold_irq, backup_mode;
   wire         sys_reset, cpu_restart, conv_start, tone_wave;
   wire [31:0]  prdata;
   wire [19:0]  p1_in, p1_out, p1_oe;
   wire [13:0]  p2_in, p2_out, p2_oe;
   wire [3:0]   od_out, od_oe, ext_irq;
   wire [15:0]  restart_addr;
   wire [2:0]   conv_channel;
   assign tone_wave = tdiv[2];
   pbrc_top uut (.ref_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
      .prdata, .pslverr, .sense_pin, .hold_pin, .reset_pin_n, .analog_pin, .p1_in, .p1_out,
      .p1_oe, .p2_in, .p2_out, .p2_oe, .od_out, .od_oe, .tone_wave, .ext_irq, .hold_irq,
      .backup_mode, .sys_reset, .cpu_restart, .restart_addr, .conv_start, .conv_channel);
   pbrc_board brd (.ref_clk, .rst_req, .p1_drv, .p1_out, .p1_oe, .p2_drv, .p2_out, .p2_oe,
      .p1_in, .p2_in, .reset_pin_n);
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
      int k;
      @(posedge ref_clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1;
      k = 0;
      do @(posedge ref_clk); while (pready !== 1'b1 && ++k < 50);
      if (k >= 50) n_fail++;
      rdat = prdata;
      rerr = pslverr;
      psel <= 0;
      penable <= 0;
      #1;
   endtask
   task automatic rd(logic [7:0] a, logic [31:0] e);
      apb(0, a, 0);
      chk("rdata", rdat, e);
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic wait_restart;
      int k;
      k = 0;
      while (cpu_restart !== 1'b1 && k < 400) begin
         cyc(1);
         k++;
      end
      chk("cpu_restart", cpu_restart, 1);
      chk("restart_addr", restart_addr, 0);
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_boot;
      cyc(1);
      chk("p1_oe", p1_oe, 0);
      chk("p2_od_oe", {p2_oe, od_oe}, 0);
      wait_restart;
      rd(8'h34, 32'h23);
   endtask
   task automatic t_ports;
      apb(1, 8'h04, 32'hf0);
      apb(1, 8'h14, 32'ha0);
      cyc(6);
      chk("p1_oe", p1_oe, 20'hf0);
      rd(8'h28, 32'h123a5);
      apb(1, 8'h20, 32'h50);
      apb(1, 8'h24, 32'h20);
      rd(8'h14, 32'hd0);
      apb(1, 8'h1c, 32'h1234);
      apb(1, 8'h08, 32'h3fff);
      apb(1, 8'h20, 32'hffffffff);
      chk("p2_out", p2_out, 14'h1234);
      rd(8'h3c, 0);
      chk("pslverr", rerr, 1);
      rd(8'h2c, 32'h1234);
   endtask
   task automatic t_analog;
      logic [31:0] n;
      apb(1, 8'h00, 32'h3a5);
      cyc(5);
      rd(8'h30, 32'h5a);
      chk("channel", conv_channel, 3);
      n = 0;
      for (int i = 0; i < 4; i++) begin
         n += conv_start;
         cyc(1);
      end
      apb(1, 8'h38, 32'h2);
      for (int i = 0; i < 4; i++) begin
         n += conv_start;
         cyc(1);
      end
      chk("conv", n, 1);
   endtask
   task automatic t_irq;
      logic [31:0] n0, n1;
      n0 = 0;
      n1 = 0;
      p1_drv <= 20'h12340;
      apb(1, 8'h10, 32'h1);
      cyc(6);
      p1_drv <= 20'h12343;
      for (int i = 0; i < 10; i++) begin
         cyc(1);
         n0 += ext_irq[0];
         n1 += ext_irq[1];
      end
      chk("irq_on", n0, 1);
      chk("irq_off", n1, 0);
   endtask
   task automatic t_tone;
      apb(1, 8'h04, 32'h1f0);
      apb(1, 8'h14, 32'h0);
      apb(1, 8'h0c, 32'h1);
      apb(1, 8'h14, 32'h100);
      rd(8'h14, 32'h100);
      for (int i = 0; i < 8; i++) begin
         cyc(1);
         chk("tone", {p1_oe[8], p1_out[8]}, {1'b1, tone_wave});
      end
      apb(1, 8'h0c, 32'h0);
      chk("latch", p1_out[8], 1);
   endtask
   task automatic t_backup;
      apb(1, 8'h18, 32'h0);
      chk("od_oe", od_oe, 4'hf);
      chk("od_out", od_out, 0);
      apb(1, 8'h38, 32'h1);
      cyc(2);
      chk("backup", backup_mode, 0);
      hold_pin <= 0;
      cyc(8);
      chk("hold_irq", hold_irq, 1);
      rd(8'h34, 32'h0f);
      apb(1, 8'h38, 32'h1);
      chk("backup", backup_mode, 1);
      chk("p1_oe", p1_oe, 0);
      chk("p2_od_oe", {p2_oe, od_oe}, 0);
      rd(8'h28, 0);
      rd(8'h2c, 0);
      rd(8'h30, 0);
      rd(8'h34, 32'h1f);
      hold_pin <= 1;
      cyc(8);
      chk("backup", backup_mode, 0);
      chk("hold_irq", hold_irq, 1);
      apb(1, 8'h34, 32'hc);
      chk("hold_irq", hold_irq, 0);
   endtask
   task automatic t_sysrst;
      sense_pin <= 0;
      cyc(8);
      rd(8'h34, 32'h20);
      sense_pin <= 1;
      rst_req <= 1;
      cyc(220);
      chk("sys_reset", sys_reset, 1);
      rst_req <= 0;
      wait_restart;
      rd(8'h34, 32'h23);
      chk("p1_oe", p1_oe, 0);
   endtask
   // ------------------------------------------------------------
   // Main
   // ------------------------------------------------------------
   initial begin
      ref_clk = 0;
      forever #4 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) tdiv <= tdiv + 3'h1;
   initial begin
      {rstn, psel, penable, pwrite, rst_req} = '0;
      paddr = '0;
      pwdata = '0;
      tdiv = '0;
      sense_pin = 1;
      hold_pin = 1;
      analog_pin = 8'hff;
      p1_drv = 20'h12345;
      p2_drv = 14'h2aaa;
      repeat (16) @(posedge ref_clk);
      rstn <= 1;
      t_boot;
      t_ports;
      t_analog;
      t_irq;
      t_tone;
      t_backup;
      t_sysrst;
      end_sim;
   end
   initial begin
      repeat (8000) @(posedge ref_clk);
      n_fail++;
      end_sim;
   end
endmodule // tb_top
